// >>> pkg/scd_map.svh
// scd_map.svh: offsets, field positions, reset values and opcode codes
// of the stack cpu opcode decoder. definitions only, include by bare name.
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

// ************************************************************
// register byte offsets on the avalon slave
// ************************************************************
`define SCD_REG_CTRL 4'h0
`define SCD_REG_STATUS 4'h4
`define SCD_REG_LAST 4'h8

// ************************************************************
// control register fields and reset value
// ************************************************************
`define SCD_CTRL_EN_BIT 0
`define SCD_CTRL_CLR_BIT 1
`define SCD_CTRL_RESET 1'h1

// ************************************************************
// instruction fields
// ************************************************************
`define SCD_POP_B_BIT 5
`define SCD_POP_A_BIT 4
`define SCD_IDX_B_LSB 2
`define SCD_IDX_A_LSB 0
`define SCD_IMM_LSB 6

// ************************************************************
// format prefixes and condition codes
// ************************************************************
`define SCD_TOP_RW 4'h0
`define SCD_TOP_UJMP 3'h7
`define SCD_TOP_BYTE 2'h2
`define SCD_TOP_SHIFT 3'h6
`define SCD_TOP_ADDI 4'hE
`define SCD_TOP_BRANCH 6'h3C
`define SCD_GLE_NEVER 3'h0

// ************************************************************
// single-operation codes in bits 11..6
// ************************************************************
`define SCD_OP_ADD 6'h10
`define SCD_OP_LIT 6'h30
`define SCD_OP_LIT_U 6'h31
`define SCD_OP_LIT_X 6'h32
`define SCD_OP_PC 6'h33
`define SCD_OP_CPY 6'h34
`define SCD_OP_POP 6'h35
`define SCD_OP_NOP 6'h36
`define SCD_OP_CLS 6'h37
`define SCD_OP_GSB 6'h38

`endif

// >>> pkg/scd_pkg.sv
// scd_pkg: types of the stack cpu opcode decoder.
// assumes scd_map.svh supplies every number.
package scd_pkg;

   // alu control handed to the data ring
   typedef enum logic [2:0] {
      scd_alu_none,
      scd_alu_add_i,
      scd_alu_shl_i,
      scd_alu_add,
      scd_alu_ext
   } scd_alu_e;

   // all registered state of the decoder
   typedef struct packed {
      logic en;
      logic ack;
      logic [31:0] rdata;
      logic [15:0] last;
      logic [15:0] taken_cnt;
      logic vld;
      logic [1:0] sel_a;
      logic [1:0] sel_b;
      logic pop_a;
      logic pop_b;
      logic cls;
      logic push;
      logic [31:0] pdata;
      scd_alu_e alu;
      logic [31:0] imm;
      logic shu;
      logic [15:0] pc;
      logic jump;
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic lit;
   } scd_state_s;

endpackage : scd_pkg

// >>> pkg/scd_cond_if.sv
// scd_cond_if: operands and test flags between decoder and comparator.
// assumes both ends run on the same clock; purely combinational signals.
`timescale 1ns/1ps
interface scd_cond_if;
   logic [31:0] a;
   logic [31:0] b;
   logic [2:0] flags;
   logic vs_zero;
   logic uns;
   logic hold;
   modport src (output a, b, flags, vs_zero, uns, input hold);
   modport eval (input a, b, flags, vs_zero, uns, output hold);
endinterface : scd_cond_if

// >>> rtl/scd_cond.sv
// scd_cond: evaluates a greater / less / equal test of A against B or zero.
// assumes operands are stable within the cycle; no state.
`timescale 1ns/1ps
module scd_cond
   import scd_pkg::*;
(
   scd_cond_if.eval c  // operands in, verdict out
);

   logic [31:0] rhs;
   logic eq;
   logic lt;
   logic gt;

   // compare and or the selected outcomes
   always_comb begin
      rhs = c.vs_zero ? 32'h0 : c.b;
      eq = (c.a == rhs);
      lt = c.uns ? (c.a < rhs) : ($signed(c.a) < $signed(rhs));
      gt = !lt && !eq;
      c.hold = (c.flags[2] && gt) || (c.flags[1] && lt) || (c.flags[0] && eq);
   end

endmodule : scd_cond

// >>> rtl/scd_decode.sv
// scd_decode: opcode decoder and branch unit of a multi-threaded stack cpu.
// assumes instr, pc, a, b, in-line word and read data arrive aligned, one
// thread slot per valid cycle, and that all controls are taken one cycle later.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "scd_map.svh"
module scd_decode
   import scd_pkg::*;
(
   input wire logic clk_in,                  // core clock
   input wire logic rst_in,                  // synchronous reset, high
   input wire logic ce_in,                   // clock enable, freezes all state
   input wire logic instr_valid_in,          // instruction slot valid
   input wire logic [15:0] instr_in,         // instruction word
   input wire logic [15:0] pc_in,            // address of this instruction
   input wire logic [31:0] a_in,             // top of selected A stack
   input wire logic [31:0] b_in,             // top of selected B stack
   input wire logic [15:0] lit_in,           // word following the instruction
   input wire logic [15:0] mem_rdata_in,     // data read at the read address
   input wire logic [3:0] avs_address_in,    // avalon byte address
   input wire logic avs_read_in,             // avalon read
   input wire logic avs_write_in,            // avalon write
   input wire logic [31:0] avs_writedata_in, // avalon write data
   output logic [31:0] avs_readdata_out,     // avalon read data
   output logic avs_waitrequest_out,         // avalon wait
   output logic dec_valid_out,               // decoded slot valid
   output logic [1:0] sel_a_out,             // A stack index
   output logic [1:0] sel_b_out,             // B stack index
   output logic pop_a_out,                   // pop A stack
   output logic pop_b_out,                   // pop B stack
   output logic stack_clear_out,             // clear this thread's stacks
   output logic push_a_out,                  // push push_data onto A
   output logic [31:0] push_data_out,        // value to push
   output scd_alu_e alu_op_out,              // alu operation
   output logic [31:0] alu_imm_out,          // alu immediate or opcode
   output logic shift_unsigned_out,          // shift is unsigned
   output logic [15:0] pc_next_out,          // next pc of the thread
   output logic pc_load_out,                 // branch taken
   output logic mem_rd_out,                  // data read strobe
   output logic mem_wr_out,                  // data write strobe
   output logic [15:0] mem_addr_out,         // data address
   output logic [15:0] mem_wdata_out,        // data write word
   output logic lit_consume_out              // in-line word consumed
);

   // ************************************************************
   // state and helpers
   // ************************************************************
   scd_state_s q, d;
   scd_cond_if cif ();
   logic [15:0] pc_nx, off4, jmp6, jmp5;
   logic [31:0] imm8_sx, imm6_sx, rd_sx;
   logic req, jz_neutral;
   logic is_rw, is_ujmp, is_cjmp, is_byte, is_shift, is_addi, is_branch;

   assign pc_nx = pc_in + 16'h0001;
   assign off4 = {12'h000, instr_in[`SCD_IMM_LSB +: 4]};
   assign imm8_sx = {{24{instr_in[13]}}, instr_in[`SCD_IMM_LSB +: 8]};
   assign imm6_sx = {{26{instr_in[11]}}, instr_in[`SCD_IMM_LSB +: 6]};
   assign jmp6 = {{10{instr_in[11]}}, instr_in[`SCD_IMM_LSB +: 6]};
   assign jmp5 = {{11{instr_in[10]}}, instr_in[`SCD_IMM_LSB +: 5]};
   assign rd_sx = {{16{mem_rdata_in[15]}}, mem_rdata_in};
   // format classes, each owning its share of opcode space
   // 000 and 111 test codes go to read/write and plain jump
   assign is_rw = (instr_in[15:12] == `SCD_TOP_RW);
   assign is_ujmp = !instr_in[15] && (instr_in[14:12] == `SCD_TOP_UJMP);
   assign is_cjmp = !instr_in[15] && !is_rw && !is_ujmp;
   assign is_byte = (instr_in[15:14] == `SCD_TOP_BYTE);
   assign is_shift = (instr_in[15:13] == `SCD_TOP_SHIFT);
   assign is_addi = (instr_in[15:12] == `SCD_TOP_ADDI);
   assign is_branch = (instr_in[15:10] == `SCD_TOP_BRANCH);

   // with the zero flag set, eq and ne test A against zero
   // the ordered codes test A against B unsigned (A below zero is moot)
   assign jz_neutral = (instr_in[14] == instr_in[13]) && (instr_in[13] != instr_in[12]);
   // signed unless the unsigned immediate variant is chosen
   assign cif.a = a_in;
   assign cif.b = b_in;
   assign cif.flags = instr_in[15] ? instr_in[8:6] : instr_in[14:12];
   assign cif.vs_zero = instr_in[15] || (instr_in[11] && jz_neutral);
   assign cif.uns = !instr_in[15] && instr_in[11] && !jz_neutral;
   scd_cond u_cond (
      .c (cif)
   );

   assign req = avs_read_in || avs_write_in;

   // ************************************************************
   // next state
   // ************************************************************
   // one answer cycle on the bus keeps the slave simple and cheap
   always_comb begin
      d = q;
      d.ack = req && !q.ack;
      if (req && !q.ack && avs_read_in) begin
         if (avs_address_in == `SCD_REG_CTRL) begin
            d.rdata = {31'h0, q.en};
         end else if (avs_address_in == `SCD_REG_STATUS) begin
            d.rdata = {16'h0000, q.taken_cnt};
         end else if (avs_address_in == `SCD_REG_LAST) begin
            d.rdata = {16'h0000, q.last};
         end else begin
            d.rdata = 32'h0;
         end
      end
      if (req && q.ack && avs_write_in && avs_address_in == `SCD_REG_CTRL) begin
         d.en = avs_writedata_in[`SCD_CTRL_EN_BIT];
         if (avs_writedata_in[`SCD_CTRL_CLR_BIT]) begin
            d.taken_cnt = 16'h0000;
         end
      end
      // per-slot controls default to idle
      d.vld = 1'b0;
      d.pop_a = 1'b0;
      d.pop_b = 1'b0;
      d.cls = 1'b0;
      d.push = 1'b0;
      d.alu = scd_alu_none;
      d.shu = 1'b0;
      d.jump = 1'b0;
      d.rd = 1'b0;
      d.wr = 1'b0;
      d.lit = 1'b0;
      if (instr_valid_in && q.en) begin
         d.vld = 1'b1;
         d.last = instr_in;
         d.pc = pc_nx;
         // index and pop fields in every format, pops forced off for nop
         // bit positions of indexes and pops
         d.sel_a = instr_in[`SCD_IDX_A_LSB +: 2];
         d.sel_b = instr_in[`SCD_IDX_B_LSB +: 2];
         d.pop_a = instr_in[`SCD_POP_A_BIT];
         d.pop_b = instr_in[`SCD_POP_B_BIT];
         if (is_rw) begin
            // one address space for code and data
            d.addr = b_in[15:0] + off4;
            if (instr_in[11]) begin
               // low half then extended high half
               d.wr = 1'b1;
               d.wdata = instr_in[10] ? a_in[31:16] : a_in[15:0];
            end else begin
               // signed low read, extended keeps low A
               d.rd = 1'b1;
               d.push = 1'b1;
               d.pdata = instr_in[10] ? {mem_rdata_in, a_in[15:0]} : rd_sx;
            end
         end else if (is_ujmp) begin
            d.pc = pc_nx + jmp6;
            d.jump = 1'b1;
         end else if (is_cjmp) begin
            // taken only when the test holds
            if (cif.hold) begin
               d.pc = pc_nx + jmp5;
               d.jump = 1'b1;
            end
         end else if (is_byte) begin
            d.push = 1'b1;
            d.pdata = imm8_sx;
         end else if (is_shift) begin
            // signed amount, unsigned flag at bit 12
            d.alu = scd_alu_shl_i;
            d.imm = imm6_sx;
            d.shu = instr_in[12];
         end else if (is_addi) begin
            d.alu = scd_alu_add_i;
            d.imm = imm6_sx;
         end else if (is_branch) begin
            if (cif.hold) begin
               d.pc = instr_in[9] ? b_in[15:0] : pc_nx + b_in[15:0];
               d.jump = 1'b1;
            end
         end else begin
            // remaining 1111 codes are single operations
            case (instr_in[11:6])
               `SCD_OP_LIT, `SCD_OP_LIT_U, `SCD_OP_LIT_X: begin
                  // next word used verbatim, skipped by the pc
                  d.push = 1'b1;
                  d.lit = 1'b1;
                  d.pc = pc_in + 16'h0002;
                  if (instr_in[11:6] == `SCD_OP_LIT_X) begin
                     d.pdata = {lit_in, a_in[15:0]};
                  end else if (instr_in[11:6] == `SCD_OP_LIT_U) begin
                     d.pdata = {16'h0000, lit_in};
                  end else begin
                     d.pdata = {{16{lit_in[15]}}, lit_in};
                  end
               end
               `SCD_OP_PC: begin
                  d.push = 1'b1;
                  d.pdata = {16'h0000, pc_nx};
               end
               `SCD_OP_CPY: begin
                  d.push = 1'b1;
                  d.pdata = b_in;
               end
               `SCD_OP_POP: begin
                  d.alu = scd_alu_none;
               end
               `SCD_OP_NOP: begin
                  d.pop_a = 1'b0;
                  d.pop_b = 1'b0;
               end
               `SCD_OP_CLS: begin
                  d.cls = 1'b1;
               end
               `SCD_OP_GSB: begin
                  d.push = 1'b1;
                  d.pdata = {16'h0000, pc_nx};
                  d.pc = b_in[15:0];
                  d.jump = 1'b1;
               end
               `SCD_OP_ADD: begin
                  d.alu = scd_alu_add;
               end
               default: begin
                  // the alu decodes the rest of the map itself
                  d.alu = scd_alu_ext;
                  d.imm = {26'h0, instr_in[11:6]};
               end
            endcase
         end
         // taken branches counted for software; clear then count, so none lost
         if (d.jump) begin
            d.taken_cnt = d.taken_cnt + 16'h0001;
         end
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q <= '0;
         q.en <= `SCD_CTRL_RESET;
      end else if (ce_in) begin
         q <= d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign avs_waitrequest_out = req && !q.ack;
   assign avs_readdata_out = q.rdata;
   assign dec_valid_out = q.vld;
   assign sel_a_out = q.sel_a;
   assign sel_b_out = q.sel_b;
   assign pop_a_out = q.pop_a;
   assign pop_b_out = q.pop_b;
   assign stack_clear_out = q.cls;
   assign push_a_out = q.push;
   assign push_data_out = q.pdata;
   assign alu_op_out = q.alu;
   assign alu_imm_out = q.imm;
   assign shift_unsigned_out = q.shu;
   assign pc_next_out = q.pc;
   assign pc_load_out = q.jump;
   assign mem_rd_out = q.rd;
   assign mem_wr_out = q.wr;
   assign mem_addr_out = q.addr;
   assign mem_wdata_out = q.wdata;
   assign lit_consume_out = q.lit;

   // ************************************************************
   // assertions
   // ************************************************************
   logic slot;
   assign slot = ce_in && instr_valid_in && q.en;

   property p_branch_pops;
      @(posedge clk_in) disable iff (rst_in)
      slot && is_branch |=> pop_a_out == $past(instr_in[4]) && pop_b_out == $past(instr_in[5]);
   endproperty
   a_branch_pops: assert property (p_branch_pops)
      else $error("branch pops not passed through");
   property p_byte_push;
      @(posedge clk_in) disable iff (rst_in)
      slot && is_byte |=> push_a_out && push_data_out == $past(imm8_sx);
   endproperty
   a_byte_push: assert property (p_byte_push)
      else $error("byte immediate push wrong");
   property p_rw_offset;
      @(posedge clk_in) disable iff (rst_in)
      slot && is_rw |=> mem_addr_out == $past(b_in[15:0]) + {12'h000, $past(instr_in[9:6])};
   endproperty
   a_rw_offset: assert property (p_rw_offset)
      else $error("read/write address offset wrong");
   property p_read_sx;
      @(posedge clk_in) disable iff (rst_in)
      slot && is_rw && instr_in[11:10] == 2'h0 |=> mem_rd_out && push_data_out[31:15] == {17{push_data_out[15]}};
   endproperty
   a_read_sx: assert property (p_read_sx)
      else $error("low read not sign extended");
   property p_rel_next;
      @(posedge clk_in) disable iff (rst_in)
      slot && is_ujmp |=> pc_load_out && pc_next_out == $past(pc_in) + 16'h0001 + $past(jmp6);
   endproperty
   a_rel_next: assert property (p_rel_next)
      else $error("relative jump not from next address");
   property p_call;
      @(posedge clk_in) disable iff (rst_in)
      slot && instr_in[15:12] == 4'hF && instr_in[11:6] == `SCD_OP_GSB |=>
         pc_next_out == $past(b_in[15:0]) && push_data_out[15:0] == $past(pc_in) + 16'h0001;
   endproperty
   a_call: assert property (p_call)
      else $error("call target or return address wrong");
   property p_never;
      @(posedge clk_in) disable iff (rst_in)
      slot && is_branch && instr_in[8:6] == `SCD_GLE_NEVER |=> !pc_load_out ##1 1'b1;
   endproperty
   a_never: assert property (p_never)
      else $error("never condition took a branch");
   property p_shift;
      @(posedge clk_in) disable iff (rst_in)
      slot && is_shift |=> alu_op_out == scd_alu_shl_i && alu_imm_out == $past(imm6_sx)
         && shift_unsigned_out == $past(instr_in[12]);
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift immediate decode wrong");
   property p_bus_answer;
      @(posedge clk_in) disable iff (rst_in)
      ce_in && req && !q.ack ##1 ce_in && req |-> !avs_waitrequest_out;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer not after one wait cycle");

endmodule : scd_decode

// >>> sim/scd_mem_model.sv
// scd_mem_model: the shared program and data memory behind the decoder.
// assumes the bench drives pc, base and offset aligned with each slot.
`timescale 1ns/1ps
module scd_mem_model (
   input wire logic clk_in,          // core clock
   input wire logic [15:0] pc_in,    // address of current instruction
   input wire logic [15:0] base_in,  // read base from the B stack
   input wire logic [3:0] off_in,    // read offset field
   input wire logic wr_in,           // data write strobe
   input wire logic [15:0] addr_in,  // data write address
   input wire logic [15:0] wdata_in, // data write word
   output logic [15:0] lit_out,      // word after the instruction
   output logic [15:0] rdata_out     // data at base plus offset
);
   // ******************
   // one array serves fetch and data
   // ******************
   logic [15:0] mem [0:65535];
   // preload a pattern so only word 46811 returns a guessable zero
   initial for (int k = 0; k < 65536; k++) mem[k] = 16'(k * 7 + 3);
   assign lit_out = mem[pc_in + 16'h1];
   assign rdata_out = mem[base_in + {12'h0, off_in}];
   // writes land at the edge that closes the strobe cycle
   // plain always: the preload above also writes the array
   always @(posedge clk_in) begin
      if (wr_in) mem[addr_in] <= wdata_in;
   end
endmodule : scd_mem_model

// >>> sim/scd_decode_bench.sv
// scd_decode_bench: random and corner checks of the opcode decoder.
// assumes scd_mem_model stands in for the pipeline memory port.
`timescale 1ns/1ps
`include "scd_map.svh"
module stack_cpu_opcode_decode_branch_bench import scd_pkg::*;;
   logic clk_in = 0;
   logic rst_in = 1;
   logic vin = 0;
   logic rd = 0;
   logic wr = 0;
   logic ce = 1;
   logic [3:0] ad = 0;
   logic [15:0] ins = 0, pc = 0, lit, mrd, pn, ma, mwd;
   logic [31:0] a = 0, b = 0, wd = 0, rdo, pd, imm;
   logic wq, dv, pa, pb, cl, push, su, ld, mr, mw, lc;
   logic [1:0] sa, sb;
   scd_alu_e op;
   int fail_count = 0, compares = 0, tk = 0;
   initial forever #12.5 clk_in = ~clk_in;
   scd_decode dut_u (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .instr_valid_in(vin),
      .instr_in(ins), .pc_in(pc), .a_in(a), .b_in(b), .lit_in(lit), .mem_rdata_in(mrd),
      .avs_address_in(ad), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_readdata_out(rdo), .avs_waitrequest_out(wq), .dec_valid_out(dv), .sel_a_out(sa),
      .sel_b_out(sb), .pop_a_out(pa), .pop_b_out(pb), .stack_clear_out(cl), .push_a_out(push),
      .push_data_out(pd), .alu_op_out(op), .alu_imm_out(imm), .shift_unsigned_out(su),
      .pc_next_out(pn), .pc_load_out(ld), .mem_rd_out(mr), .mem_wr_out(mw),
      .mem_addr_out(ma), .mem_wdata_out(mwd), .lit_consume_out(lc));
   scd_mem_model mem_u (.clk_in(clk_in), .pc_in(pc), .base_in(b[15:0]), .off_in(ins[9:6]),
      .wr_in(mw), .addr_in(ma), .wdata_in(mwd), .lit_out(lit), .rdata_out(mrd));
   // ******************
   // helpers
   // ******************
   task automatic tally_and_finish;
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // addresses wrap at 16 bits, so sums are kept in a 16 bit result
   function automatic logic [15:0] add16(input logic [15:0] u, v);
      return u + v;
   endfunction : add16
   // ored greater, less and equal test
   function automatic logic tst(input logic [2:0] f, input logic [31:0] x, y, input logic u);
      logic lt;
      lt = u ? (x < y) : ($signed(x) < $signed(y));
      return (f[2] & !lt & (x != y)) | (f[1] & lt) | (f[0] & (x == y));
   endfunction : tst
   // one avalon access; the request stands until waitrequest is seen low
   task automatic av(input logic w, input logic [3:0] av_a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      @(posedge clk_in);
      rd <= !w;
      wr <= w;
      ad <= av_a;
      wd <= d;
      // looked at on the rising edge itself, before the slave's flops move
      for (n = 0; n < 20; n++) begin
         @(posedge clk_in);
         if (wq === 1'b0) break;
      end
      if (n == 20) begin
         fail_count++;
         tally_and_finish();
      end
      q = rdo;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : av
   // one instruction slot; returns once the decoded pulse is visible
   task automatic sl(input logic [15:0] i, p, input logic [31:0] x, y);
      @(posedge clk_in);
      ins <= i;
      pc <= p;
      a <= x;
      b <= y;
      vin <= 1'b1;
      @(posedge clk_in);
      vin <= 1'b0;
      #1;
   endtask : sl
   task automatic br(input logic t, input logic [15:0] tg);
      chk("pc_load", ld, t);
      if (t) chk("pc_next", pn, tg);
      chk("pop_a", pa, ins[4]);
      chk("pop_b", pb, ins[5]);
      chk("sel", {sb, sa}, ins[3:0]);
      tk += t;
   endtask : br
   // ******************
   // main sequence
   // ******************
   initial begin
      logic [31:0] q, x, y;
      logic [15:0] i, p, e, w;
      logic [2:0] f;
      int k;
      void'($urandom(41));
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      av(0, `SCD_REG_CTRL, 0, q);
      chk("ctrl", q, 32'h1);
      av(1, `SCD_REG_CTRL, 32'h3, q);
      for (k = 0; k < 45; k++) begin
         p = $urandom;
         x = ($urandom % 4 == 0) ? 0 : $urandom;
         y = ($urandom % 3 == 0) ? x : $urandom;
         i = $urandom;
         sl({2'b10, i[13:0]}, p, x, y);
         chk("valid", dv, 1'b1);
         chk("byte", pd, {{24{i[13]}}, i[13:6]});
         chk("pc_seq", pn, add16(p, 16'h1));
         sl({4'hE, i[11:0]}, p, x, y);
         chk("add_op", op, scd_alu_add_i);
         chk("add_imm", imm, {{26{i[11]}}, i[11:6]});
         sl({3'b110, i[12:0]}, p, x, y);
         chk("shift_op", op, scd_alu_shl_i);
         chk("shift_imm", imm, {{26{i[11]}}, i[11:6]});
         chk("shift_uns", su, i[12]);
         sl({5'h0, i[10:0]}, p, x, y);
         e = add16(y[15:0], {12'h0, i[9:6]});
         chk("rd_addr", ma, e);
         chk("rd_data", pd, i[10] ? {mrd, x[15:0]} : {{16{mrd[15]}}, mrd});
         chk("rd_strobe", {mr, mw}, 2'b10);
         sl({5'h1, i[10:0]}, p, x, y);
         w = i[10] ? x[31:16] : x[15:0];
         chk("wr_addr", ma, e);
         chk("wr_data", mwd, w);
         chk("wr_strobe", {mr, mw}, 2'b01);
         sl({4'hF, `SCD_OP_LIT + 6'(k % 3), i[5:0]}, add16(e, 16'hFFFF), x, y);
         chk("lit", pd, (k % 3 == 0) ? {{16{w[15]}}, w} :
            (k % 3 == 1) ? {16'h0, w} : {w, x[15:0]});
         chk("lit_pc", pn, add16(e, 16'h1));
         f = 3'($urandom_range(1, 6));
         sl({1'b0, f, i[11:0]}, p, x, y);
         br((i[11] && (f == 1 || f == 6)) ? tst(f, x, 0, 0) : tst(f, x, y, i[11]),
            add16(add16(p, 16'h1), {{11{i[10]}}, i[10:6]}));
         sl({4'h7, i[11:0]}, p, x, y);
         br(1'b1, add16(add16(p, 16'h1), {{10{i[11]}}, i[11:6]}));
         f = 3'($urandom);
         sl({6'h3C, i[9], f, i[5:0]}, p, x, y);
         br(tst(f, x, 0, 0), i[9] ? y[15:0] : add16(add16(p, 16'h1), y[15:0]));
         sl({4'hF, `SCD_OP_GSB, i[5:0]}, p, x, y);
         br(1'b1, y[15:0]);
         chk("ret", pd, {16'h0, add16(p, 16'h1)});
         sl({6'h3C, 1'b1, 3'h7, i[5:0]}, p, x, y);
         br(1'b1, y[15:0]);
         // single operations 0x30..0x37, one per pass
         sl({4'hF, `SCD_OP_LIT + 6'(k % 8), i[5:0]}, p, x, y);
         chk("lit_use", lc, k % 8 < 3);
         if (k % 8 < 3) chk("lit_skip", pn, add16(p, 16'h2));
         chk("clear", cl, k % 8 == 7);
         chk("push", push, k % 8 < 5);
         chk("nop_pop", {pb, pa}, (k % 8 == 6) ? 2'b00 : ins[5:4]);
         if (k % 8 == 3) chk("pc_push", pd, {16'h0, add16(p, 16'h1)});
         if (k % 8 == 4) chk("copy", pd, y);
         // register add and a code left to the alu
         sl({4'hF, (k % 2) ? `SCD_OP_ADD : 6'h21, i[5:0]}, p, x, y);
         chk("alu_op", op, (k % 2) ? scd_alu_add : scd_alu_ext);
         if (k % 2 == 0) chk("alu_code", imm, 32'h21);
      end
      // clock enable low must hold the last decoded pulse
      sl(16'h8000, p, x, y);
      ce <= 1'b0;
      @(posedge clk_in);
      #1;
      chk("frozen", dv, 1'b1);
      ce <= 1'b1;
      av(0, `SCD_REG_STATUS, 0, q);
      chk("taken", q, tk);
      av(0, `SCD_REG_LAST, 0, q);
      chk("last", q, {16'h0, ins});
      av(0, 4'hC, 0, q);
      chk("unmapped", q, 0);
      av(1, `SCD_REG_CTRL, 0, q);
      sl(16'h8000, 0, 0, 0);
      chk("disabled", dv, 1'b0);
      tally_and_finish();
   end
   // a hang counts as a mismatch
   initial begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
endmodule : stack_cpu_opcode_decode_branch_bench
